// ### hw/paq_pkg.sv
package paq_pkg;

	// ---------------------------------------------------------------
	// widths and register map
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned FRAC_W = 8;
	localparam int unsigned MEP_W = 10;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_AQ_A = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_AQ_B = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_CMP_A = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_CMP_B = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_CMP_C = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_CMP_D = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_FORCE = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_FRAC = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_STAT = 6'h24;
	localparam logic [ADDR_W-1:0] REG_STRIDE = 6'h04;
	localparam logic [1:0] ALIGN_OK = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// fine edge timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 100000;
	localparam int unsigned MEP_STEP_PS = 150;
	localparam logic [MEP_W-1:0] MEP_SCALE =
		MEP_W'(CLK_PERIOD_PS / MEP_STEP_PS);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PAQ_ACT_NONE, PAQ_ACT_CLR, PAQ_ACT_SET, PAQ_ACT_TGL
	} paq_act_t;

	typedef enum logic [1:0] {
		PAQ_CF_OFF, PAQ_CF_LOW, PAQ_CF_HIGH, PAQ_CF_RSVD
	} paq_cf_t;

	// zero, period, either, or the mode-specific fourth choice
	typedef enum logic [1:0] {
		PAQ_LD_ZERO, PAQ_LD_PRD, PAQ_LD_EITHER, PAQ_LD_OTHER
	} paq_ld_t;

	typedef struct packed {
		paq_act_t cbd;
		paq_act_t cmp_b_upcount_event;
		paq_act_t cad;
		paq_act_t cmp_a_upcount_event;
		paq_act_t period_match_event;
		paq_act_t zero;
	} paq_aq_t;

	typedef struct packed {
		logic cbd;
		logic cmp_b_upcount_event;
		logic cad;
		logic cmp_a_upcount_event;
		logic period_match_event;
		logic zero;
	} paq_evt_t;

	typedef struct packed {
		logic [3:0] link_en;
		logic [3:0] cmp_imm;
		logic duty_prd;
		logic ctl_phase;
		paq_ld_t frac_ld;
		logic swap;
		logic inv_b;
		logic en_b;
		logic en_a;
	} paq_ctrl_t;

	typedef struct packed {
		paq_act_t swf_act_b;
		paq_act_t swf_act_a;
		logic go_b;
		logic go_a;
		paq_ld_t swf_ld;
		paq_ld_t cf_ld;
		paq_cf_t cf_b;
		paq_cf_t cf_a;
	} paq_force_t;

	localparam paq_aq_t AQ_A_RST = 12'h096;
	localparam paq_aq_t AQ_B_RST = 12'h929;
	localparam paq_ctrl_t CTRL_RST = 16'h0001;
	localparam paq_force_t FORCE_RST = 14'h0000;
	localparam logic [2*FRAC_W-1:0] FRAC_RST = 16'h0000;

endpackage

// ### hw/paq_cmp_unit.sv
// one compare register with shadow, link and direction-qualified match
module paq_cmp_unit
	import paq_pkg::*;
#(
	parameter int unsigned CW = CNT_W
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [CW-1:0] wr_data,
	input wire logic shadow_imm,
	input wire logic link_en,
	input wire logic [CW-1:0] link_val,
	input wire logic [CW-1:0] timebase_counter,
	input wire logic tb_count_up,
	output logic [CW-1:0] active_q,
	output logic up_evt,
	output logic dn_evt,
	output logic hit
);

	logic [CW-1:0] shadow_q;
	logic [CW-1:0] eff;

	// software writes always land in the shadow copy
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow_q <= '0;
		end else if (wr_en) begin
			shadow_q <= wr_data;
		end
	end

	// active value: immediate write or shadow transfer at zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			active_q <= '0;
		end else if (shadow_imm) begin
			if (wr_en) begin
				active_q <= wr_data;
			end
		end else if (timebase_counter == '0) begin
			active_q <= shadow_q;
		end
	end

	// match against own or linked value, split by direction
	assign eff = link_en ? link_val : active_q;
	assign hit = (timebase_counter == eff);
	assign up_evt = hit && tb_count_up;
	assign dn_evt = hit && !tb_count_up;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	chk_shadow_hold: assert property (
		(!shadow_imm && timebase_counter != '0) |=> $stable(active_q))
		else $error("shadowed compare changed away from zero");
	chk_shadow_load: assert property (
		(!shadow_imm && timebase_counter == '0)
		|=> active_q == $past(shadow_q))
		else $error("shadow not transferred at zero");
	chk_link_match: assert property (
		(link_en && tb_count_up && timebase_counter == link_val)
		|-> up_evt)
		else $error("linked compare value not used");

endmodule

// ### hw/paq_top.sv
// The address map and register access over AXI4-Lite were left to the implementer.
module paq_top
	import paq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [CNT_W-1:0] timebase_counter,
	input wire logic [CNT_W-1:0] timebase_period,
	input wire logic tb_count_up,
	input wire logic [3:0][CNT_W-1:0] link_cmp_val,
	output logic pwm_out_a,
	output logic pwm_out_b,
	output paq_evt_t cmp_evt,
	output logic [3:0] cmp_match,
	output logic [FRAC_W-1:0] fine_edge_pos,
	output logic [MEP_W-1:0] mep_steps
);

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	paq_ctrl_t ctrl_q;
	paq_aq_t aq_a_q, aq_b_q;
	paq_force_t force_q;
	logic [2*FRAC_W-1:0] frac_sh_q;
	logic go_a_q, go_b_q;
	paq_act_t swf_act_a_q, swf_act_b_q;
	paq_cf_t cf_act_a_q, cf_act_b_q;
	logic [FRAC_W-1:0] compare_reg_a_frac_act_q, prd_frac_act_q;
	logic wave_a_q, wave_b_q;
	logic [3:0][CNT_W-1:0] cmp_act;
	logic [3:0] cmp_up, cmp_dn, cmp_hit;

	// bus state
	logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q, rdata_q, wr_val;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_fire;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a[1:0] == ALIGN_OK) && (a <= OFS_STAT);
	endfunction

	function automatic logic [31:0] reg_rd(input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		paq_force_t f;
		v = 32'h0;
		f = force_q;
		f.go_a = 1'b0;
		f.go_b = 1'b0;
		case (a)
			OFS_CTRL: v[$bits(paq_ctrl_t)-1:0] = ctrl_q;
			OFS_AQ_A: v[$bits(paq_aq_t)-1:0] = aq_a_q;
			OFS_AQ_B: v[$bits(paq_aq_t)-1:0] = aq_b_q;
			OFS_CMP_A: v[CNT_W-1:0] = cmp_act[0];
			OFS_CMP_B: v[CNT_W-1:0] = cmp_act[1];
			OFS_CMP_C: v[CNT_W-1:0] = cmp_act[2];
			OFS_CMP_D: v[CNT_W-1:0] = cmp_act[3];
			OFS_FORCE: v[$bits(paq_force_t)-1:0] = f;
			OFS_FRAC: v[2*FRAC_W-1:0] = frac_sh_q;
			OFS_STAT: v[15:0] = {fine_edge_pos, 2'h0, pwm_out_b,
				pwm_out_a, cf_act_b_q, cf_act_a_q};
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction

	// reload strobe for a load select; other_hit covers the fourth code
	function automatic logic ld_hit(input paq_ld_t s, input logic z,
		input logic p, input logic other_hit);
		unique case (s)
			PAQ_LD_ZERO: return z;
			PAQ_LD_PRD: return p;
			PAQ_LD_EITHER: return z || p;
			PAQ_LD_OTHER: return other_hit;
		endcase
	endfunction

	// event priority: software force, then B down/up, A down/up, period, zero
	function automatic paq_act_t resolve(input paq_aq_t aq,
		input paq_evt_t e, input logic go, input paq_act_t swf);
		if (go) return swf;
		if (e.cbd) return aq.cbd;
		if (e.cmp_b_upcount_event) return aq.cmp_b_upcount_event;
		if (e.cad) return aq.cad;
		if (e.cmp_a_upcount_event) return aq.cmp_a_upcount_event;
		if (e.period_match_event) return aq.period_match_event;
		if (e.zero) return aq.zero;
		return PAQ_ACT_NONE;
	endfunction

	function automatic logic next_wave(input paq_cf_t cf,
		input paq_act_t a, input logic cur);
		if (cf == PAQ_CF_LOW) return 1'b0;
		if (cf == PAQ_CF_HIGH) return 1'b1;
		unique case (a)
			PAQ_ACT_NONE: return cur;
			PAQ_ACT_CLR: return 1'b0;
			PAQ_ACT_SET: return 1'b1;
			PAQ_ACT_TGL: return !cur;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	assign wr_val = merge(reg_rd(waddr_q), wdata_q, wstrb_q);

	// address and data are caught in either order
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_got_q <= 1'b0;
			waddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_q <= 1'b1;
			waddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_got_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_got_q <= 1'b0;
		end
	end

	// write response follows the register update
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read data is captured when the address is taken
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= reg_rd(s_axi_araddr);
			rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CTRL_RST;
			aq_a_q <= AQ_A_RST;
			aq_b_q <= AQ_B_RST;
			frac_sh_q <= FRAC_RST;
		end else if (wr_fire) begin
			if (waddr_q == OFS_CTRL) ctrl_q <= wr_val[$bits(paq_ctrl_t)-1:0];
			if (waddr_q == OFS_AQ_A) aq_a_q <= wr_val[$bits(paq_aq_t)-1:0];
			if (waddr_q == OFS_AQ_B) aq_b_q <= wr_val[$bits(paq_aq_t)-1:0];
			if (waddr_q == OFS_FRAC) frac_sh_q <= wr_val[2*FRAC_W-1:0];
		end
	end

	// force register image of the write, read field by field
	paq_force_t force_wr;
	assign force_wr = wr_val[$bits(paq_force_t)-1:0];

	// force shadow register; go bits become one-cycle force events
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			force_q <= FORCE_RST;
			go_a_q <= 1'b0;
			go_b_q <= 1'b0;
		end else begin
			go_a_q <= 1'b0;
			go_b_q <= 1'b0;
			if (wr_fire && waddr_q == OFS_FORCE) begin
				force_q <= wr_val[$bits(paq_force_t)-1:0];
				force_q.go_a <= 1'b0;
				force_q.go_b <= 1'b0;
				go_a_q <= force_wr.go_a;
				go_b_q <= force_wr.go_b;
			end
		end
	end

	// ---------------------------------------------------------------
	// compare units and events
	// ---------------------------------------------------------------
	logic zero_hit, prd_hit;
	paq_evt_t evt;
	paq_act_t act_a, act_b;

	assign zero_hit = (timebase_counter == '0);
	assign prd_hit = (timebase_counter == timebase_period);

	for (genvar i = 0; i < 4; i++) begin : g_cmp
		paq_cmp_unit #(
			.CW(CNT_W)
		) u_cmp (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.wr_en(wr_fire && waddr_q ==
				ADDR_W'(OFS_CMP_A + ADDR_W'(i) * REG_STRIDE)),
			.wr_data(wr_val[CNT_W-1:0]),
			.shadow_imm(ctrl_q.cmp_imm[i]),
			.link_en(ctrl_q.link_en[i]),
			.link_val(link_cmp_val[i]),
			.timebase_counter(timebase_counter),
			.tb_count_up(tb_count_up),
			.active_q(cmp_act[i]),
			.up_evt(cmp_up[i]),
			.dn_evt(cmp_dn[i]),
			.hit(cmp_hit[i])
		);
	end

	// events seen by the qualifier, compare matches split by count direction
	always_comb begin
		evt.zero = zero_hit;
		evt.period_match_event = prd_hit;
		evt.cmp_a_upcount_event = cmp_up[0];
		evt.cad = cmp_dn[0];
		evt.cmp_b_upcount_event = cmp_up[1];
		evt.cbd = cmp_dn[1];
	end

	// registered event outputs for interrupt and conversion start logic
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_evt <= '0;
			cmp_match <= 4'h0;
		end else begin
			cmp_evt <= evt;
			cmp_match <= cmp_hit;
		end
	end

	// ---------------------------------------------------------------
	// action qualifier
	// ---------------------------------------------------------------
	// active force settings reload from the force shadow register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			swf_act_a_q <= PAQ_ACT_NONE;
			swf_act_b_q <= PAQ_ACT_NONE;
			cf_act_a_q <= PAQ_CF_OFF;
			cf_act_b_q <= PAQ_CF_OFF;
		end else begin
			if (ld_hit(force_q.swf_ld, zero_hit, prd_hit, 1'b0)) begin
				swf_act_a_q <= force_q.swf_act_a;
				swf_act_b_q <= force_q.swf_act_b;
			end
			if (ld_hit(force_q.cf_ld, zero_hit, prd_hit, 1'b1)) begin
				cf_act_a_q <= force_q.cf_a;
				cf_act_b_q <= force_q.cf_b;
			end
		end
	end

	assign act_a = resolve(aq_a_q, evt, go_a_q, swf_act_a_q);
	assign act_b = resolve(aq_b_q, evt, go_b_q, swf_act_b_q);

	// raw waveforms, continuous force taking precedence
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_a_q <= 1'b0;
			wave_b_q <= 1'b0;
		end else begin
			wave_a_q <= next_wave(cf_act_a_q, act_a, wave_a_q);
			wave_b_q <= next_wave(cf_act_b_q, act_b, wave_b_q);
		end
	end

	// output routing: invert A onto B, then swap, then enables
	logic route_b, sel_a, sel_b;
	assign route_b = ctrl_q.inv_b ? !wave_a_q : wave_b_q;
	assign sel_a = ctrl_q.swap ? route_b : wave_a_q;
	assign sel_b = ctrl_q.swap ? wave_a_q : route_b;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
		end else begin
			pwm_out_a <= ctrl_q.en_a && sel_a;
			pwm_out_b <= ctrl_q.en_b && sel_b;
		end
	end

	// ---------------------------------------------------------------
	// fine edge positioning
	// ---------------------------------------------------------------
	logic [FRAC_W-1:0] fine_sel;
	logic [FRAC_W+MEP_W-1:0] fine_prod;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_reg_a_frac_act_q <= '0;
			prd_frac_act_q <= '0;
		end else if (ld_hit(ctrl_q.frac_ld, zero_hit, prd_hit,
			zero_hit || prd_hit)) begin
			compare_reg_a_frac_act_q <= frac_sh_q[FRAC_W-1:0];
			prd_frac_act_q <= frac_sh_q[2*FRAC_W-1:FRAC_W];
		end
	end

	assign fine_sel = (ctrl_q.ctl_phase || ctrl_q.duty_prd) ?
		prd_frac_act_q : compare_reg_a_frac_act_q;
	assign fine_prod = fine_sel * MEP_SCALE;

	// fraction of a clock turned into a count of fine steps
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fine_edge_pos <= '0;
			mep_steps <= '0;
		end else begin
			fine_edge_pos <= fine_sel;
			mep_steps <= fine_prod[FRAC_W +: MEP_W];
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	chk_out_disabled_low: assert property (
		!ctrl_q.en_a |=> !pwm_out_a)
		else $error("disabled output A not low");
	chk_action_set: assert property (
		(cf_act_a_q == PAQ_CF_OFF && act_a == PAQ_ACT_SET) |=> wave_a_q)
		else $error("set action did not raise A");
	chk_action_toggle: assert property (
		(cf_act_b_q == PAQ_CF_OFF && act_b == PAQ_ACT_TGL)
		|=> wave_b_q != $past(wave_b_q))
		else $error("toggle action did not invert B");
	chk_force_go: assert property (
		(go_a_q && cf_act_a_q == PAQ_CF_OFF && swf_act_a_q == PAQ_ACT_CLR)
		|=> !wave_a_q)
		else $error("one-shot force clear ignored");
	chk_swf_frozen: assert property (
		force_q.swf_ld == PAQ_LD_OTHER |=> $stable(swf_act_a_q))
		else $error("frozen force action reloaded");
	chk_cont_low: assert property (
		cf_act_a_q == PAQ_CF_LOW |=> !wave_a_q ##1 1'b1)
		else $error("continuous force low not held");
	chk_cont_imm: assert property (
		force_q.cf_ld == PAQ_LD_OTHER |=> cf_act_b_q == $past(force_q.cf_b))
		else $error("immediate continuous force not applied");
	chk_inv_route: assert property (
		(ctrl_q.inv_b && !ctrl_q.swap && ctrl_q.en_b)
		|=> pwm_out_b == !$past(wave_a_q))
		else $error("B is not inverted A");
	chk_swap_route: assert property (
		(ctrl_q.swap && !ctrl_q.inv_b && ctrl_q.en_a)
		|=> pwm_out_a == $past(wave_b_q))
		else $error("swap did not route B to A");
	chk_frac_zero: assert property (
		(ctrl_q.frac_ld == PAQ_LD_ZERO && zero_hit)
		|=> compare_reg_a_frac_act_q == $past(frac_sh_q[FRAC_W-1:0]))
		else $error("fraction not loaded at zero");
	chk_phase_frac: assert property (
		ctrl_q.ctl_phase |=> fine_edge_pos == $past(prd_frac_act_q))
		else $error("phase mode not using period fraction");
	chk_mep_range: assert property (
		mep_steps < MEP_SCALE)
		else $error("fine step count beyond one clock");
	chk_cmp_event: assert property (
		(tb_count_up && !ctrl_q.link_en[0] && timebase_counter == cmp_act[0])
		|=> cmp_evt.cmp_a_upcount_event)
		else $error("compare A up match lost");
	chk_dir_qual: assert property (
		cmp_dn[1] |-> !tb_count_up)
		else $error("down event while counting up");

endmodule

// ### verification/paq_load.sv
module paq_load (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic pwm_out_a,
	output logic [7:0] rise_a
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_a_q;

	// count turn-on edges that the switch on pin a sees
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_a_q <= 1'h0;
			rise_a <= 8'h00;
		end else begin
			last_a_q <= pwm_out_a;
			if (pwm_out_a && !last_a_q)
				rise_a <= rise_a + 8'h01;
		end
	end
endmodule

// ### verification/tb_pwm_action_qualifier_compare.sv
module tb_pwm_action_qualifier_compare import paq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] lo;
		logic [7:0] hi;
		logic dn;
		logic ea;
		logic eb;
	} paq_step_t;
	localparam paq_step_t STEPS [9] = '{
		'{8'h03, 8'h00, 8'h05, 1'h0, 1'h1, 1'h0},
		'{8'h03, 8'h06, 8'h0a, 1'h0, 1'h0, 1'h1},
		'{8'h03, 8'h0b, 8'h0e, 1'h0, 1'h0, 1'h0},
		'{8'h07, 8'h0e, 8'h0e, 1'h0, 1'h0, 1'h1},
		'{8'h03, 8'h0f, 8'h14, 1'h0, 1'h0, 1'h1},
		'{8'h0b, 8'h14, 8'h14, 1'h0, 1'h1, 1'h0},
		'{8'h03, 8'h13, 8'h09, 1'h1, 1'h0, 1'h1},
		'{8'h03, 8'h08, 8'h05, 1'h1, 1'h1, 1'h1},
		'{8'h01, 8'h05, 8'h05, 1'h1, 1'h1, 1'h0}};
	logic sys_clk = 1'h0;
	logic arst_n = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [CNT_W-1:0] timebase_counter = 16'h0001;
	logic [CNT_W-1:0] timebase_period = 16'h0014;
	logic tb_count_up = 1'h1;
	logic [3:0][CNT_W-1:0] link_cmp_val = '0;
	logic pwm_out_a, pwm_out_b;
	paq_evt_t cmp_evt;
	logic [3:0] cmp_match;
	logic [FRAC_W-1:0] fine_edge_pos;
	logic [MEP_W-1:0] mep_steps;
	logic [7:0] rise_a;
	int errors = 0;
	int num_checks = 0;

	paq_top DUT (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timebase_counter,
		.timebase_period, .tb_count_up, .link_cmp_val, .pwm_out_a,
		.pwm_out_b, .cmp_evt, .cmp_match, .fine_edge_pos, .mep_steps);
	paq_load load (.sys_clk, .arst_n, .pwm_out_a, .rise_a);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic pa, pw, ta, tw;
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		pa = 1'h1;
		pw = 1'h1;
		n = 0;
		while ((pa || pw) && n < 50) begin
			@(negedge sys_clk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge sys_clk);
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
			pa = pa && !ta;
			pw = pw && !tw;
			n++;
		end
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (!s_axi_bvalid && n < 50);
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'h1, er});
		@(posedge sys_clk);
		s_axi_bready <= 1'h0;
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (!s_axi_arready && n < 50);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'h0;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (!s_axi_rvalid && n < 50);
		chk(s_axi_rdata, exp);
		chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'h1, er});
		@(posedge sys_clk);
		s_axi_rready <= 1'h0;
	endtask

	// walk the counter one step a clock, then let the outputs settle
	task automatic sweep(input logic [7:0] lo, input logic [7:0] hi,
		input logic dn);
		logic [7:0] v;
		v = lo;
		forever begin
			@(posedge sys_clk);
			timebase_counter <= {8'h00, v};
			tb_count_up <= !dn;
			if (v == hi)
				break;
			v = dn ? v - 8'h01 : v + 8'h01;
		end
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog and tests
	// ---------------------------------------------------------------
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	// cut a hang short well after the tests should have ended
	initial begin
		repeat (4000) @(posedge sys_clk);
		errors++;
		$display("watchdog expired");
		close_out();
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'h1;
		rdc(OFS_CTRL, 32'(CTRL_RST), RESP_OKAY);
		rdc(OFS_AQ_A, 32'(AQ_A_RST), RESP_OKAY);
		rdc(OFS_AQ_B, 32'(AQ_B_RST), RESP_OKAY);
		rdc(6'h28, 32'h0, RESP_SLVERR);
		axw(6'h3c, 32'h0, RESP_SLVERR);
		$display("test reset_values done");
		axw(OFS_CMP_A, 32'h8, RESP_OKAY);
		axw(OFS_CMP_B, 32'hc, RESP_OKAY);
		axw(OFS_FRAC, 32'h40, RESP_OKAY);
		rdc(OFS_CMP_A, 32'h0, RESP_OKAY);
		chk(32'(fine_edge_pos), 32'h0);
		// one pass through zero loads the shadows before the waveform steps
		sweep(8'h00, 8'h01, 1'h0);
		$display("test shadow_hold done");
		for (int i = 0; i < 9; i++) begin
			axw(OFS_CTRL, {24'h0, STEPS[i].ctl}, RESP_OKAY);
			sweep(STEPS[i].lo, STEPS[i].hi, STEPS[i].dn);
			chk(32'(pwm_out_a), 32'(STEPS[i].ea));
			chk(32'(pwm_out_b), 32'(STEPS[i].eb));
		end
		chk(32'(rise_a), 32'h3);
		rdc(OFS_CMP_A, 32'h8, RESP_OKAY);
		chk(32'(fine_edge_pos), 32'h40);
		chk(32'(mep_steps), (32'h40 * 32'(MEP_SCALE)) >> 8);
		// compare C follows the linked value; A matches while counting down
		link_cmp_val[2] <= 16'h0008;
		axw(OFS_CTRL, 32'h4001, RESP_OKAY);
		sweep(8'h08, 8'h08, 1'h1);
		chk(32'(cmp_evt), 32'h08);
		chk(32'(cmp_match), 32'h5);
		$display("test waveform done");
		axw(OFS_CTRL, 32'h3, RESP_OKAY);
		axw(OFS_FORCE, 32'h35, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(pwm_out_a), 32'h0);
		chk(32'(pwm_out_b), 32'h0);
		rdc(OFS_STAT, 32'h4005, RESP_OKAY);
		axw(OFS_FORCE, 32'h3a, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({30'h0, pwm_out_a, pwm_out_b}, 32'h3);
		$display("test force done");
		close_out();
	end
endmodule
